// [rtl/lbs_pkg.sv]
// Package with the constants and carrier types of the latched-bus working-storage memory.
// ============================================================================
// How it works
// RULE_01 - The memory holds 256 words of 8 bits, addressed by an 8-bit address taken off the bus.
// RULE_02 - With master enable high the address is held and the bus is never driven.
// RULE_03 - Enable low, load high, write low: the bus is latched as address on the clock fall.
// RULE_04 - Enable low, load low, write high: the bus byte is written on the clock fall.
// RULE_05 - Enable, load and write all low: the addressed byte is driven, whatever the clock.
// RULE_06 - Read drive starts after the load strobe falls and stops after it rises.
// RULE_07 - Read drive starts after master enable falls and stops after it rises.
// RULE_08 - The processor never raises load and write strobes together.
// RULE_09 - Address and data share one two-way bus with no glue logic.
// RULE_10 - The processor does not drive the bus while the memory is reading.
package lbs_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned DEPTH = 256;
    localparam int unsigned SYNC_STAGES = 2;

    // Sampled control pins, all taken through the pin synchronisers.
    typedef struct packed {
        logic master_enable_n;
        logic address_load_strobe;
        logic write_strobe;
        logic master_clk;
    } lbs_ctrl_t;

    typedef enum logic [1:0] {
        LBS_IDLE,
        LBS_LOAD,
        LBS_WRITE,
        LBS_READ
    } lbs_mode_t;
endpackage

// [rtl/lbs_mem.sv]
// Single-port storage array with registered read data.
`timescale 1ns/1ps
module lbs_mem #(
    parameter int unsigned ADDR_W = lbs_pkg::ADDR_W,
    parameter int unsigned DATA_W = lbs_pkg::DATA_W,
    parameter int unsigned DEPTH = lbs_pkg::DEPTH
) (
    input wire logic clk_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] mem [DEPTH];

    // ========================================================================
    // Storage
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i; // [RULE_01]
        end
    end

    // Read-during-write returns the new byte so a read right after a write is fresh.
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule // lbs_mem

// [rtl/lbs_sram.sv]
// Top of the latched-bus working-storage memory: pin sampling, mode decode, bus drive.
`timescale 1ns/1ps
module lbs_sram #(
    parameter int unsigned ADDR_W = lbs_pkg::ADDR_W,
    parameter int unsigned DATA_W = lbs_pkg::DATA_W,
    parameter int unsigned DEPTH = lbs_pkg::DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic master_enable_n_i,
    input wire logic address_load_strobe_i,
    input wire logic write_strobe_i,
    input wire logic master_clk_i,
    input wire logic [DATA_W-1:0] shared_io_bus_i,
    output logic [DATA_W-1:0] shared_io_bus_o,
    output logic shared_io_bus_oe_o
);
    // ========================================================================
    // Pin synchronisers
    // Every pin is asynchronous to clk_i, so all of them pass two flops; the bus
    // data is delayed equally so it lines up with the strobes it belongs to.
    // The idle level keeps the master clock low so that leaving reset never
    // looks like a falling edge.
    localparam lbs_pkg::lbs_ctrl_t CTRL_IDLE = '{master_enable_n: 1'b1, default: 1'b0};

    lbs_pkg::lbs_ctrl_t ctrl_pins;
    lbs_pkg::lbs_ctrl_t ctrl_stage [lbs_pkg::SYNC_STAGES];
    logic [DATA_W-1:0] bus_stage [lbs_pkg::SYNC_STAGES];
    lbs_pkg::lbs_ctrl_t ctrl;
    logic [DATA_W-1:0] bus_sync;
    logic mclk_prev;

    assign ctrl_pins = '{master_enable_n: master_enable_n_i,
                         address_load_strobe: address_load_strobe_i,
                         write_strobe: write_strobe_i,
                         master_clk: master_clk_i};

    for (genvar s = 0; s < lbs_pkg::SYNC_STAGES; s++) begin : g_sync
        if (s == 0) begin : g_first
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    ctrl_stage[s] <= CTRL_IDLE;
                end else begin
                    ctrl_stage[s] <= ctrl_pins;
                end
            end

            always_ff @(posedge clk_i) begin
                bus_stage[s] <= shared_io_bus_i; // [RULE_09]
            end
        end else begin : g_next
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    ctrl_stage[s] <= CTRL_IDLE;
                end else begin
                    ctrl_stage[s] <= ctrl_stage[s-1];
                end
            end

            always_ff @(posedge clk_i) begin
                bus_stage[s] <= bus_stage[s-1];
            end
        end
    end

    assign ctrl = ctrl_stage[lbs_pkg::SYNC_STAGES-1];
    assign bus_sync = bus_stage[lbs_pkg::SYNC_STAGES-1];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mclk_prev <= 1'b0;
        end else begin
            mclk_prev <= ctrl.master_clk;
        end
    end

    // ========================================================================
    // Mode decode
    lbs_pkg::lbs_mode_t mode;
    logic mclk_fall;

    assign mclk_fall = mclk_prev && !ctrl.master_clk;

    always_comb begin
        mode = lbs_pkg::LBS_IDLE; // [RULE_02]
        if (!ctrl.master_enable_n) begin
            case ({ctrl.address_load_strobe, ctrl.write_strobe})
                2'b10: mode = lbs_pkg::LBS_LOAD; // [RULE_03]
                2'b01: mode = lbs_pkg::LBS_WRITE; // [RULE_04]
                2'b00: mode = lbs_pkg::LBS_READ; // [RULE_05]
                // Both strobes high is forbidden; treat it as hold and release.
                2'b11: mode = lbs_pkg::LBS_IDLE; // [RULE_08]
                default: mode = lbs_pkg::LBS_IDLE;
            endcase
        end
    end

    // ========================================================================
    // Address latch
    logic [ADDR_W-1:0] addr_latch;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            addr_latch <= '0;
        end else if (mode == lbs_pkg::LBS_LOAD && mclk_fall) begin
            addr_latch <= bus_sync[ADDR_W-1:0]; // [RULE_03]
        end
    end

    // ========================================================================
    // Storage and write
    logic mem_we;
    logic [DATA_W-1:0] rdata;

    assign mem_we = (mode == lbs_pkg::LBS_WRITE) && mclk_fall; // [RULE_04]

    lbs_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .DEPTH(DEPTH)
    ) u_mem (
        .clk_i(clk_i),
        .we_i(mem_we),
        .addr_i(addr_latch),
        .wdata_i(bus_sync),
        .rdata_o(rdata)
    );

    // ========================================================================
    // Bus drive
    // Drive follows the synchronised strobes, so it starts and ends a few clk_i
    // cycles after the pins move; the processor must leave that much margin.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            shared_io_bus_oe_o <= 1'b0;
            shared_io_bus_o <= '0;
        end else begin
            shared_io_bus_oe_o <= (mode == lbs_pkg::LBS_READ); // [RULE_05] [RULE_06] [RULE_07]
            shared_io_bus_o <= rdata; // [RULE_10]
        end
    end
endmodule // lbs_sram

// [sim/lbs_chk.sv]
// Pin checker for the latched-bus memory.
`timescale 1ns/1ps
module lbs_chk (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic master_enable_n_i,
    input wire logic address_load_strobe_i,
    input wire logic write_strobe_i,
    input wire logic shared_io_bus_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire [2:0] p = {master_enable_n_i, address_load_strobe_i, write_strobe_i};
    wire oe = shared_io_bus_oe_o;
    chk_off_quiet: assert property (p[2] [*3] |=> !oe) else $error("bad drive");
    chk_load_quiet: assert property ((p == 3'h2) [*3] |=> !oe) else $error("bad drive");
    chk_write_quiet: assert property ((p == 3'h1) [*3] |=> !oe) else $error("bad drive");
    chk_both_quiet: assert property ((p == 3'h3) [*3] |=> !oe) else $error("bad drive");
    chk_read_drive: assert property (!p [*3] |=> oe) else $error("no drive");
    chk_load_release: assert property ($rose(p[1]) |-> ##3 !oe) else $error("late");
    chk_enable_release: assert property ($rose(p[2]) |-> ##3 !oe) else $error("late");
    chk_drive_cause: assert property ($rose(oe) |-> !$past(p, 3)) else $error("early");
    cover property (!p [*3]);
    cover property ((p == 3'h2) [*3]);
    cover property ((p == 3'h1) [*3]);
endmodule // lbs_chk
bind lbs_sram lbs_chk i_lbs_chk (.*);

// [sim/lbs_host.sv]
// Processor model: works the memory pins and shares its bus.
`timescale 1ns/1ps
module lbs_host (
    input wire logic clk_i,
    input wire logic oe_i,
    input wire logic [7:0] dev_i,
    output lbs_pkg::lbs_ctrl_t ctrl_o,
    output logic [7:0] bus_o
);
    logic [7:0] hv = 8'h00;
    logic rel = 1'b1;
    initial ctrl_o = 4'h9;
    // Released, the bus shows the inverse of the last byte so stale data cannot pass.
    assign bus_o = oe_i ? dev_i : rel ? ~hv : hv;
    task automatic put(input logic [3:0] c, input logic [7:0] v, input logic r);
        @(posedge clk_i);
        #1 {ctrl_o, hv, rel} = {c, v, r};
        repeat (2) @(posedge clk_i);
    endtask
endmodule // lbs_host

// [sim/lbs_sram_tb.sv]
// Self-checking bench for the latched-bus memory.
`timescale 1ns/1ps
module lbs_sram_tb;
    logic clk_i = 1'b0, reset_i = 1'b1, oe;
    logic [7:0] bus, dev;
    lbs_pkg::lbs_ctrl_t c;
    int fail_count = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;
    lbs_host i_lbs_host (.clk_i, .oe_i(oe), .dev_i(dev), .ctrl_o(c), .bus_o(bus));
    lbs_sram i_lbs_sram (.clk_i, .reset_i, .master_enable_n_i(c[3]),
        .address_load_strobe_i(c[2]), .write_strobe_i(c[1]), .master_clk_i(c[0]),
        .shared_io_bus_i(bus), .shared_io_bus_o(dev), .shared_io_bus_oe_o(oe));
    task automatic end_sim;
        $display("failed %0d of %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %0t %h %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic s);
        i_lbs_host.put(s ? 4'h5 : 4'h0, a, !s);
        i_lbs_host.put(s ? 4'h4 : 4'h0, a, !s);
        i_lbs_host.put(4'h0, a, 1'b1);
        repeat (6) if (oe !== 1'b1) @(negedge clk_i);
        chk({7'h00, oe}, 8'h01);
        chk(dev, e);
        i_lbs_host.put(4'h8, a, 1'b1);
        repeat (2) @(negedge clk_i);
        chk({7'h00, oe}, 8'h00);
    endtask
    task automatic t_rw;
        logic [7:0] v [4] = '{8'h00, 8'ha5, 8'hff, 8'h3c};
        for (int k = 0; k < 8; k++) i_lbs_host.put(4'(5 - k % 4), v[k / 2], 1'b0);
        rd(8'hff, 8'h3c, 1'b1);
        rd(8'h00, 8'ha5, 1'b1);
    endtask
    task automatic t_hold;
        for (int k = 0; k < 6; k++) i_lbs_host.put(4'(k < 4 ? 13 - k : 6), 8'hff, 1'b0);
        rd(8'hff, 8'ha5, 1'b0);
        rd(8'hff, 8'h3c, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clk_i);
        #1 reset_i = 1'b0;
        t_rw();
        t_hold();
        end_sim();
    end
    // About 2.3 us of traffic; the margin only ends a stuck wait.
    initial begin
        #20000 fail_count++;
        end_sim();
    end
endmodule // lbs_sram_tb
